// [hw/san_pkg.sv]
// Package: constants and types for the sanitize command block
package san_pkg;
  localparam logic [7:0] CMD_SANITIZE = 8'hb4;
  localparam logic [15:0] FEAT_STATUS = 16'h0000;
  localparam logic [15:0] FEAT_CRYPTO = 16'h0011;
  localparam logic [15:0] FEAT_OVERWRITE = 16'h0014;
  localparam logic [15:0] FEAT_FREEZE = 16'h0020;
  localparam logic [7:0] CMD_IDENTIFY = 8'hec;
  localparam logic [7:0] CMD_READ_LOG = 8'h2f;
  localparam logic [7:0] CMD_READ_LOG_DMA = 8'h47;
  localparam logic [7:0] CMD_READ_SECT = 8'h20;
  localparam logic [7:0] CMD_READ_SECT_EXT = 8'h24;
  localparam logic [7:0] CMD_DOWNLOAD = 8'h92;
  localparam logic [7:0] CMD_FORMAT_TRACK = 8'h50;
  localparam logic [7:0] LOG_E0 = 8'he0;
  localparam logic [7:0] LOG_30 = 8'h30;
  localparam logic [7:0] LOG_10 = 8'h10;
  localparam int SECTOR_BYTES = 512;
  localparam int PASS_W = 4;

  typedef enum logic [2:0] {
    SANITIZE_IDLE_STATE = 3'h0,
    SANITIZE_FROZEN_STATE = 3'h1,
    SANITIZE_RUNNING_STATE = 3'h2,
    SANITIZE_FAILED_STATE = 3'h3,
    SANITIZE_SUCCEEDED_STATE = 3'h4
  } san_state_t;

  typedef enum logic [1:0] {
    SAN_PR_READY = 2'h0,
    SAN_PR_BUSY = 2'h1,
    SAN_PR_DATA = 2'h2
  } san_proto_t;
endpackage : san_pkg

// [hw/san_dec_if.sv]
// Interface: command fields out to the decoder and its verdicts back
`timescale 1ns/1ps
`default_nettype none
interface san_dec_if;
  logic [7:0] code;
  logic [15:0] feature;
  logic [7:0] log_addr;
  logic sanitize;
  logic bypass;
  logic pio_in;
  logic pio_out;
  modport dec (input code, feature, log_addr, output sanitize, bypass, pio_in, pio_out);
  modport req (output code, feature, log_addr, input sanitize, bypass, pio_in, pio_out);
endinterface : san_dec_if
`default_nettype wire

// [hw/san_cmd_decode.sv]
// Command classifier: sanitize family, bypass set, data protocol
`timescale 1ns/1ps
`default_nettype none
module san_cmd_decode (
  // Decoder side of the carrier
  san_dec_if.dec d
);
  logic log_ok;

  // Log pages readable while a sanitize is active
  always_comb begin
    log_ok = (d.log_addr == san_pkg::LOG_E0) || (d.log_addr == san_pkg::LOG_30) ||
             (d.log_addr == san_pkg::LOG_10);
  end

  // Opcode classes
  always_comb begin
    d.sanitize = (d.code == san_pkg::CMD_SANITIZE);
    d.bypass = (d.code == san_pkg::CMD_IDENTIFY) ||
               (d.sanitize && d.feature == san_pkg::FEAT_STATUS) ||
               ((d.code == san_pkg::CMD_READ_LOG || d.code == san_pkg::CMD_READ_LOG_DMA)
                && log_ok);
    d.pio_in = (d.code == san_pkg::CMD_IDENTIFY) || (d.code == san_pkg::CMD_READ_LOG) ||
               (d.code == san_pkg::CMD_READ_SECT) || (d.code == san_pkg::CMD_READ_SECT_EXT);
    d.pio_out = (d.code == san_pkg::CMD_DOWNLOAD) || (d.code == san_pkg::CMD_FORMAT_TRACK);
  end
endmodule : san_cmd_decode
`default_nettype wire

// [hw/san_sector_xfer.sv]
// Sector counter for programmed data phases
`timescale 1ns/1ps
`default_nettype none
module san_sector_xfer #(
  parameter int SECTOR_BYTES = san_pkg::SECTOR_BYTES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Control
  input wire logic i_start,
  input wire logic [7:0] i_sectors,
  input wire logic i_abort,
  input wire logic i_byte,
  // Status
  output logic o_done
);
  typedef struct packed {
    logic active;
    logic [9:0] bytes;
    logic [7:0] left;
    logic done;
  } san_xfer_t;

  san_xfer_t st;
  san_xfer_t next_st;

  // Count bytes into whole sectors, finish on the last byte of the last one
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (i_abort) begin
      next_st.active = 1'b0;
    end else if (i_start) begin
      next_st.active = 1'b1;
      // Data request is already up in the start cycle, so a byte there counts
      next_st.bytes = i_byte ? 10'h001 : 10'h000;
      next_st.left = (i_sectors == 8'h00) ? 8'h01 : i_sectors;
    end else if (st.active && i_byte) begin
      if (st.bytes == 10'(SECTOR_BYTES - 1)) begin
        next_st.bytes = 10'h000;
        next_st.left = st.left - 8'h01;
        if (st.left == 8'h01) begin
          next_st.active = 1'b0;
          next_st.done = 1'b1;
        end
      end else begin
        next_st.bytes = st.bytes + 10'h001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_done = st.done;
endmodule : san_sector_xfer
`default_nettype wire

// [hw/san_dev.sv]
// Sanitize command interpreter with status handshake and state tracking
`timescale 1ns/1ps
`default_nettype none
module san_dev #(
  parameter bit ENCRYPT = 1'b0,
  parameter int PASS_W = san_pkg::PASS_W
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Command from host
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_code,
  input wire logic [15:0] i_cmd_feature,
  input wire logic [31:0] i_cmd_lba,
  input wire logic [7:0] i_cmd_count,
  input wire logic [7:0] i_cmd_log,
  input wire logic i_cmd_invert,
  input wire logic i_cmd_fail_mode,
  input wire logic i_cmd_clear_fail,
  // Host events
  input wire logic i_status_read,
  input wire logic i_hw_reset,
  input wire logic i_sw_reset,
  input wire logic i_por,
  input wire logic i_data_byte,
  // Erase engine
  input wire logic i_erase_done,
  input wire logic i_erase_error,
  output logic o_erase_start,
  output logic o_erase_crypto,
  output logic [31:0] o_erase_pattern,
  output logic [PASS_W-1:0] o_erase_passes,
  output logic o_erase_invert,
  // Status to host
  output logic o_bsy,
  output logic o_drq,
  output logic o_rdy,
  output logic o_err,
  output logic o_intrq,
  output logic [2:0] o_san_state
);
  typedef struct packed {
    san_pkg::san_state_t san;
    san_pkg::san_proto_t proto;
    logic bsy;
    logic drq;
    logic rdy;
    logic err;
    logic intrq;
    logic fail_mode;
    logic erase_start;
    logic crypto;
    logic invert;
    logic [31:0] pattern;
    logic [PASS_W-1:0] passes;
    logic [7:0] code;
    logic [15:0] feature;
    logic [7:0] count;
    logic [7:0] log_addr;
    logic c_invert;
    logic c_fail_mode;
    logic c_clear;
    logic xfer_start;
  } san_dev_t;

  san_dev_t st;
  san_dev_t next_st;
  san_dec_if dec ();
  logic xfer_done;
  logic host_reset;
  logic field_reset;
  logic erase_cmd;
  logic erase_ok;
  logic allowed;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  san_cmd_decode u_dec (
    .d(dec)
  );

  san_sector_xfer #(
    .SECTOR_BYTES(san_pkg::SECTOR_BYTES)
  ) u_xfer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_start(st.xfer_start),
    .i_sectors(st.count),
    .i_abort(host_reset),
    .i_byte(i_data_byte),
    .o_done(xfer_done)
  );

  // Decoder looks at the latched command
  assign dec.code = st.code;
  assign dec.feature = st.feature;
  assign dec.log_addr = st.log_addr;

  // Command qualifiers
  always_comb begin
    host_reset = i_hw_reset || i_sw_reset;
    field_reset = i_hw_reset || i_por;
    erase_cmd = dec.sanitize && (st.feature == san_pkg::FEAT_OVERWRITE ||
                                 st.feature == san_pkg::FEAT_CRYPTO);
    erase_ok = (st.feature == san_pkg::FEAT_OVERWRITE) || ENCRYPT;
    // Running admits only the bypass set; failed and succeeded also take erase commands
    case (st.san)
      san_pkg::SANITIZE_IDLE_STATE, san_pkg::SANITIZE_FROZEN_STATE: allowed = 1'b1;
      san_pkg::SANITIZE_RUNNING_STATE: allowed = dec.bypass;
      default: allowed = dec.bypass || erase_cmd;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;
    next_st.erase_start = 1'b0;
    next_st.xfer_start = 1'b0;
    // Interrupt clear first so a completion in the same cycle wins
    if (i_status_read) begin
      next_st.intrq = 1'b0;
    end
    // Engine finishing
    if (st.san == san_pkg::SANITIZE_RUNNING_STATE && i_erase_done) begin
      next_st.san = i_erase_error ? san_pkg::SANITIZE_FAILED_STATE
                                  : san_pkg::SANITIZE_SUCCEEDED_STATE;
    end
    // Hardware and power-on resets; running and failed hold, idle stays idle
    if (field_reset && (st.san == san_pkg::SANITIZE_FROZEN_STATE ||
                        st.san == san_pkg::SANITIZE_SUCCEEDED_STATE)) begin
      next_st.san = san_pkg::SANITIZE_IDLE_STATE;
    end
    case (st.proto)
      san_pkg::SAN_PR_READY: begin
        if (i_cmd_valid && !host_reset) begin
          next_st.proto = san_pkg::SAN_PR_BUSY;
          next_st.bsy = 1'b1;
          next_st.rdy = 1'b0;
          next_st.err = 1'b0;
          next_st.intrq = 1'b0;
          next_st.code = i_cmd_code;
          next_st.feature = i_cmd_feature;
          next_st.count = i_cmd_count;
          next_st.log_addr = i_cmd_log;
          next_st.pattern = i_cmd_lba;
          next_st.c_invert = i_cmd_invert;
          next_st.c_fail_mode = i_cmd_fail_mode;
          next_st.c_clear = i_cmd_clear_fail;
        end
      end
      san_pkg::SAN_PR_BUSY: begin
        // Default completion: busy falls with an interrupt
        next_st.proto = san_pkg::SAN_PR_READY;
        next_st.bsy = 1'b0;
        next_st.rdy = 1'b1;
        next_st.intrq = 1'b1;
        if (!allowed) begin
          next_st.err = 1'b1;
        end else if (dec.sanitize) begin
          if (st.feature == san_pkg::FEAT_STATUS) begin
            if (st.san == san_pkg::SANITIZE_SUCCEEDED_STATE) begin
              next_st.san = san_pkg::SANITIZE_IDLE_STATE;
            end else if (st.san == san_pkg::SANITIZE_FAILED_STATE) begin
              if (st.c_clear && st.fail_mode) begin
                next_st.san = san_pkg::SANITIZE_IDLE_STATE;
              end else begin
                next_st.err = 1'b1;
              end
            end
          end else if (st.feature == san_pkg::FEAT_FREEZE) begin
            if (st.san == san_pkg::SANITIZE_IDLE_STATE) begin
              next_st.san = san_pkg::SANITIZE_FROZEN_STATE;
            end else if (st.san != san_pkg::SANITIZE_FROZEN_STATE) begin
              next_st.err = 1'b1;
            end
          end else if (erase_cmd && erase_ok &&
                       st.san != san_pkg::SANITIZE_FROZEN_STATE) begin
            next_st.san = san_pkg::SANITIZE_RUNNING_STATE;
            next_st.fail_mode = st.c_fail_mode;
            next_st.erase_start = 1'b1;
            next_st.crypto = (st.feature == san_pkg::FEAT_CRYPTO);
            next_st.invert = st.c_invert;
            next_st.passes = st.count[PASS_W-1:0];
          end else begin
            next_st.err = 1'b1;
          end
        end else if (dec.pio_in || dec.pio_out) begin
          // Busy hands over to data request in the same edge
          next_st.proto = san_pkg::SAN_PR_DATA;
          next_st.drq = 1'b1;
          next_st.rdy = 1'b0;
          next_st.intrq = 1'b0;
          next_st.xfer_start = 1'b1;
        end
      end
      san_pkg::SAN_PR_DATA: begin
        if (xfer_done) begin
          next_st.proto = san_pkg::SAN_PR_READY;
          next_st.drq = 1'b0;
          next_st.rdy = 1'b1;
          next_st.intrq = 1'b1;
        end
      end
      default: next_st.proto = san_pkg::SAN_PR_READY;
    endcase
    // Hardware or software reset aborts the command and clears the interrupt
    if (host_reset) begin
      next_st.proto = san_pkg::SAN_PR_READY;
      next_st.bsy = 1'b0;
      next_st.drq = 1'b0;
      next_st.rdy = 1'b1;
      next_st.intrq = 1'b0;
      next_st.xfer_start = 1'b0;
      // Running takes no state-changing command, so an engine completion still lands
      if (st.proto == san_pkg::SAN_PR_BUSY && st.san != san_pkg::SANITIZE_RUNNING_STATE) begin
        next_st.erase_start = 1'b0;
        next_st.san = field_reset && (st.san == san_pkg::SANITIZE_FROZEN_STATE ||
                      st.san == san_pkg::SANITIZE_SUCCEEDED_STATE) ?
                      san_pkg::SANITIZE_IDLE_STATE : st.san;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st <= '0;
      st.rdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign o_erase_start = st.erase_start;
  assign o_erase_crypto = st.crypto;
  assign o_erase_pattern = st.pattern;
  assign o_erase_passes = st.passes;
  assign o_erase_invert = st.invert;
  assign o_bsy = st.bsy;
  assign o_drq = st.drq;
  assign o_rdy = st.rdy;
  assign o_err = st.err;
  assign o_intrq = st.intrq;
  assign o_san_state = st.san;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  AST_BSY_OR_DRQ: assert property (
    st.proto != san_pkg::SAN_PR_READY |-> (st.bsy || st.drq))
    else $error("busy and data request both low mid command");

  AST_FREEZE: assert property (
    st.proto == san_pkg::SAN_PR_BUSY && dec.sanitize && st.feature == san_pkg::FEAT_FREEZE &&
    st.san == san_pkg::SANITIZE_IDLE_STATE && !host_reset
    |=> st.san == san_pkg::SANITIZE_FROZEN_STATE && !st.err && st.intrq)
    else $error("freeze lock did not freeze");

  AST_FROZEN_ABORT: assert property (
    st.proto == san_pkg::SAN_PR_BUSY && erase_cmd && st.san == san_pkg::SANITIZE_FROZEN_STATE &&
    !host_reset |=> st.err && st.san == san_pkg::SANITIZE_FROZEN_STATE && !st.erase_start)
    else $error("erase not aborted while frozen");

  AST_FROZEN_RESET: assert property (
    st.san == san_pkg::SANITIZE_FROZEN_STATE && field_reset
    |=> st.san == san_pkg::SANITIZE_IDLE_STATE)
    else $error("frozen kept across reset");

  AST_RUN_HOLD: assert property (
    st.san == san_pkg::SANITIZE_RUNNING_STATE && !i_erase_done
    |=> st.san == san_pkg::SANITIZE_RUNNING_STATE)
    else $error("left running without completion");

  AST_RUN_DONE: assert property (
    st.san == san_pkg::SANITIZE_RUNNING_STATE && i_erase_done
    |=> st.san == ($past(i_erase_error) ? san_pkg::SANITIZE_FAILED_STATE
                                        : san_pkg::SANITIZE_SUCCEEDED_STATE))
    else $error("wrong state after erase completion");

  AST_FAIL_STAY: assert property (
    st.san == san_pkg::SANITIZE_FAILED_STATE && st.proto != san_pkg::SAN_PR_BUSY
    |=> st.san == san_pkg::SANITIZE_FAILED_STATE)
    else $error("failed state left without a command");

  AST_SUCC_RESET: assert property (
    st.san == san_pkg::SANITIZE_SUCCEEDED_STATE && field_reset
    |=> st.san == san_pkg::SANITIZE_IDLE_STATE)
    else $error("succeeded kept across reset");

  AST_START_PULSE: assert property (
    st.erase_start |-> st.san == san_pkg::SANITIZE_RUNNING_STATE ##1 !st.erase_start)
    else $error("erase start not a single pulse into running");

  AST_INTR_CLEAR: assert property (
    i_status_read && st.proto == san_pkg::SAN_PR_READY |=> !st.intrq)
    else $error("status read left interrupt pending");

  AST_CRYPTO: assert property (
    st.proto == san_pkg::SAN_PR_BUSY && erase_cmd && !erase_ok && !host_reset |=> st.err)
    else $error("crypto erase accepted without encryption");
endmodule : san_dev
`default_nettype wire

// [testbench/san_host.sv]
// Host controller model that writes commands into the device
`timescale 1ns/1ps
`default_nettype none
module san_host (
  // Clock
  input wire logic i_clk,
  // Device status
  input wire logic i_bsy,
  input wire logic i_drq,
  input wire logic i_rdy,
  // Command to device
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_code,
  output logic [15:0] o_cmd_feature,
  output logic [31:0] o_cmd_lba,
  output logic [7:0] o_cmd_count,
  output logic o_cmd_fail_mode,
  output logic o_cmd_clear_fail,
  output logic o_cmd_invert,
  output logic [7:0] o_cmd_log
);
  int waits;
  // Quiet bus at time zero
  initial begin
    o_cmd_valid = 1'b0;
    {o_cmd_code, o_cmd_feature, o_cmd_lba, o_cmd_count, o_cmd_log} = '0;
    {o_cmd_fail_mode, o_cmd_clear_fail, o_cmd_invert} = 3'h0;
  end
  // Waits for a free device, then holds the command across one edge
  task automatic issue(input logic [7:0] code, input logic [15:0] feat,
    input logic [7:0] cnt, input logic fm, input logic clr, input logic inv,
    input logic [7:0] lg);
    waits = 0;
    @(negedge i_clk);
    while ((i_bsy !== 1'b0 || i_drq !== 1'b0 || i_rdy !== 1'b1) && waits < 100) begin
      waits++;
      @(negedge i_clk);
    end
    o_cmd_valid = 1'b1;
    {o_cmd_code, o_cmd_feature, o_cmd_count} = {code, feat, cnt};
    o_cmd_lba = 32'ha5c3_0f1e;
    {o_cmd_fail_mode, o_cmd_clear_fail, o_cmd_invert} = {fm, clr, inv};
    o_cmd_log = lg;
    @(negedge i_clk);
    o_cmd_valid = 1'b0;
    // Unqualified fields show the inverse, not a stale copy
    {o_cmd_code, o_cmd_feature, o_cmd_count} = ~{code, feat, cnt};
    o_cmd_lba = ~o_cmd_lba;
    {o_cmd_fail_mode, o_cmd_clear_fail, o_cmd_invert} = ~{fm, clr, inv};
    o_cmd_log = ~lg;
  endtask : issue
endmodule : san_host
`default_nettype wire

// [testbench/san_dev_test.sv]
// Self-checking testbench for the sanitize command block
`timescale 1ns/1ps
`default_nettype none
module san_dev_test;
  logic clk, rst_n, srd, hw, sw, por, dbyte, edone, eerr;
  logic cv, fm, clr, cinv, es, ec, einv, bsy, drq, rdy, err, irq, last_start;
  logic [7:0] code, cnt, clog;
  logic [15:0] feat;
  logic [31:0] lba, epat;
  logic [san_pkg::PASS_W-1:0] epass;
  logic [2:0] st;
  int n_fail, num_checks, cycles;

  san_host san_host_inst (.i_clk(clk), .i_bsy(bsy), .i_drq(drq), .i_rdy(rdy),
    .o_cmd_valid(cv), .o_cmd_code(code), .o_cmd_feature(feat), .o_cmd_lba(lba),
    .o_cmd_count(cnt), .o_cmd_fail_mode(fm), .o_cmd_clear_fail(clr),
    .o_cmd_invert(cinv), .o_cmd_log(clog));
  san_dev #(.ENCRYPT(1'b0)) san_dev_inst (.i_clk(clk), .i_rst_n(rst_n),
    .i_cmd_valid(cv), .i_cmd_code(code), .i_cmd_feature(feat), .i_cmd_lba(lba),
    .i_cmd_count(cnt), .i_cmd_log(clog), .i_cmd_invert(cinv), .i_cmd_fail_mode(fm),
    .i_cmd_clear_fail(clr), .i_status_read(srd), .i_hw_reset(hw), .i_sw_reset(sw),
    .i_por(por), .i_data_byte(dbyte), .i_erase_done(edone), .i_erase_error(eerr),
    .o_erase_start(es), .o_erase_crypto(ec), .o_erase_pattern(epat),
    .o_erase_passes(epass), .o_erase_invert(einv), .o_bsy(bsy), .o_drq(drq),
    .o_rdy(rdy), .o_err(err), .o_intrq(irq), .o_san_state(st));

  ////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts it
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Prints the counts and the verdict, then stops
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // Issues a command, feeds any data phase and judges the completion
  task automatic run_cmd(input logic [7:0] c, input logic [15:0] f, input logic [7:0] n_s,
    input logic m, input logic k, input logic e, input logic [2:0] s, input int bytes,
    input logic inv, input logic [7:0] lg);
    int n;
    int nb;
    int nq;
    logic seen;
    logic done;
    n = 0;
    nb = 0;
    nq = 0;
    seen = 1'b0;
    done = 1'b0;
    san_host_inst.issue(c, f, n_s, m, k, inv, lg);
    while (n < 3000) begin
      // Feed only the bytes the command owes; data request lingers one cycle after
      dbyte = (drq === 1'b1) && (nb < bytes);
      if (drq === 1'b1) nq++;
      if (dbyte) nb++;
      if (bsy === 1'b1 || drq === 1'b1) begin
        if (!seen) chk("intrq_at_take", 32'h0, irq);
        seen = 1'b1;
      end else if (seen && rdy === 1'b1) begin
        done = 1'b1;
        break;
      end else if (seen) chk("bsy_or_drq", 32'h1, 32'h0);
      n++;
      @(negedge clk);
    end
    dbyte = 1'b0;
    last_start = es;
    chk("completed", 32'h1, done);
    chk("err", e, err);
    chk("state", s, st);
    chk("intrq_done", 32'h1, irq);
    chk("data_bytes", bytes, nb);
    chk("drq_cycles", bytes + (bytes > 0), nq);
  endtask : run_cmd

  // Sanitize family command with the fixed pass count field
  task automatic san(input logic [15:0] f, input logic m, input logic k, input logic e,
    input logic [2:0] s);
    run_cmd(san_pkg::CMD_SANITIZE, f, 8'h13, m, k, e, s, 0, 1'b1, 8'h00);
  endtask : san

  // Pulses {status read, hw reset, sw reset, power-on} and checks the state
  task automatic evt(input logic [3:0] m, input logic [2:0] s);
    @(negedge clk);
    {srd, hw, sw, por} = m;
    @(negedge clk);
    {srd, hw, sw, por} = 4'h0;
    @(negedge clk);
    chk("state_after_event", s, st);
  endtask : evt

  // Erase engine reports the end of an operation
  task automatic erase(input logic e, input logic [2:0] s);
    @(negedge clk);
    {edone, eerr} = {1'b1, e};
    @(negedge clk);
    {edone, eerr} = 2'h0;
    @(negedge clk);
    chk("state_after_erase", s, st);
  endtask : erase

  ////////////////////////////////////////////////////////////////////////////
  // Idle state, feature decode and interrupt clearing
  task automatic t_idle();
    chk("rdy_reset", 32'h1, rdy);
    chk("state_reset", 32'h0, st);
    san(san_pkg::FEAT_STATUS, 1'b0, 1'b0, 1'b0, 3'h0);
    evt(4'h8, 3'h0);
    chk("intrq_status_read", 32'h0, irq);
    evt(4'h4, 3'h0);
    evt(4'h1, 3'h0);
    san(16'h0015, 1'b0, 1'b0, 1'b1, 3'h0);
    san(san_pkg::FEAT_CRYPTO, 1'b0, 1'b0, 1'b1, 3'h0);
    evt(4'h4, 3'h0);
    chk("intrq_hw_reset", 32'h0, irq);
    run_cmd(san_pkg::CMD_READ_SECT, 16'h0, 8'h02, 1'b0, 1'b0, 1'b0, 3'h0,
      1024, 1'b0, 8'h00);
    $display("test idle done");
  endtask : t_idle

  // Frozen state entry, refusals and exits
  task automatic t_frozen();
    san(san_pkg::FEAT_FREEZE, 1'b0, 1'b0, 1'b0, 3'h1);
    san(san_pkg::FEAT_OVERWRITE, 1'b0, 1'b0, 1'b1, 3'h1);
    san(san_pkg::FEAT_STATUS, 1'b0, 1'b0, 1'b0, 3'h1);
    evt(4'h1, 3'h0);
    san(san_pkg::FEAT_FREEZE, 1'b0, 1'b0, 1'b0, 3'h1);
    evt(4'h4, 3'h0);
    $display("test frozen done");
  endtask : t_frozen

  // Running state: start, holds, allowed set, clean finish
  task automatic t_run();
    san(san_pkg::FEAT_OVERWRITE, 1'b0, 1'b0, 1'b0, 3'h2);
    chk("erase_start", 32'h1, last_start);
    chk("pattern", 32'ha5c3_0f1e, epat);
    chk("passes", 32'h3, epass);
    chk("invert", 32'h1, einv);
    chk("crypto", 32'h0, ec);
    san(san_pkg::FEAT_STATUS, 1'b0, 1'b0, 1'b0, 3'h2);
    evt(4'h4, 3'h2);
    evt(4'h1, 3'h2);
    evt(4'h2, 3'h2);
    run_cmd(san_pkg::CMD_READ_SECT, 16'h0, 8'h01, 1'b0, 1'b0, 1'b1, 3'h2,
      0, 1'b0, 8'h00);
    run_cmd(san_pkg::CMD_IDENTIFY, 16'h0, 8'h01, 1'b0, 1'b0, 1'b0, 3'h2,
      512, 1'b0, 8'h00);
    run_cmd(san_pkg::CMD_READ_LOG, 16'h0, 8'h01, 1'b0, 1'b0, 1'b0, 3'h2,
      512, 1'b0, 8'h30);
    run_cmd(san_pkg::CMD_READ_LOG, 16'h0, 8'h01, 1'b0, 1'b0, 1'b1, 3'h2,
      0, 1'b0, 8'h05);
    run_cmd(san_pkg::CMD_READ_LOG_DMA, 16'h0, 8'h01, 1'b0, 1'b0, 1'b0, 3'h2,
      0, 1'b0, 8'h10);
    erase(1'b0, 3'h4);
    $display("test running done");
  endtask : t_run

  // Failed state holds, recovery and restart
  task automatic t_fail();
    san(san_pkg::FEAT_OVERWRITE, 1'b0, 1'b0, 1'b0, 3'h2);
    erase(1'b1, 3'h3);
    san(san_pkg::FEAT_STATUS, 1'b0, 1'b0, 1'b1, 3'h3);
    evt(4'h4, 3'h3);
    evt(4'h1, 3'h3);
    san(san_pkg::FEAT_STATUS, 1'b0, 1'b1, 1'b1, 3'h3);
    run_cmd(san_pkg::CMD_SANITIZE, san_pkg::FEAT_OVERWRITE, 8'h13, 1'b1, 1'b0, 1'b0, 3'h2,
      0, 1'b0, 8'h00);
    chk("invert_clear", 32'h0, einv);
    erase(1'b1, 3'h3);
    san(san_pkg::FEAT_STATUS, 1'b0, 1'b1, 1'b0, 3'h0);
    $display("test failed done");
  endtask : t_fail

  // Succeeded state left by each of its three events
  task automatic t_succ();
    logic [3:0] ev [3];
    ev = '{4'h4, 4'h1, 4'h0};
    for (int i = 0; i < 3; i++) begin
      san(san_pkg::FEAT_OVERWRITE, 1'b0, 1'b0, 1'b0, 3'h2);
      erase(1'b0, 3'h4);
      if (ev[i] != 4'h0) evt(ev[i], 3'h0);
      else san(san_pkg::FEAT_STATUS, 1'b0, 1'b0, 1'b0, 3'h0);
    end
    $display("test succeeded done");
  endtask : t_succ

  ////////////////////////////////////////////////////////////////////////////
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Cuts a hung run short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_fail++;
      complete_run();
    end
  end

  // Reset, then the scenarios in order
  initial begin
    {rst_n, srd, hw, sw, por, dbyte, edone, eerr} = 8'h0;
    {n_fail, num_checks, cycles} = '0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_idle();
    t_frozen();
    t_run();
    t_fail();
    t_succ();
    complete_run();
  end
endmodule : san_dev_test
`default_nettype wire
